// ### sim/brake_relay_model.sv
// Brake relay coil model: reports whether the holding brake is locked
`timescale 1ns/1ps
module brake_relay_model (
   input  wire logic coil_drive,
   output logic      brake_locked
);
   // Coil off locks
   // Spring brake: unpowered coil locks, and it never releases on its own
   assign brake_locked = !coil_drive;
endmodule

// ### sim/brake_seq_asserts.sv
// Checker: port-level properties of the brake release sequencer
`timescale 1ns/1ps
module brake_seq_asserts #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        servo_on_input,
   input wire logic [15:0] motor_speed,
   input wire logic        brake_release_output
);
   // ---------------------------------
   // Bus and brake output properties
   // ---------------------------------
   // One domain, so clock and reset are given once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_one_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready missing in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside a completing access");
   a_rise_needs_on: assert property ($rose(brake_release_output) |-> $past(servo_on_input))
      else $error("brake released without servo on");
   a_engage_after_off: assert property ($fell(brake_release_output) |-> !$past(servo_on_input))
      else $error("brake engaged before servo off");
   a_engaged_holds: assert property (!servo_on_input && !brake_release_output
      |=> !brake_release_output)
      else $error("brake released while servo off");
   a_released_holds: assert property (servo_on_input && brake_release_output
      |=> brake_release_output)
      else $error("brake engaged while servo on");
   a_reset_engaged: assert property ($rose(presetn) |-> !brake_release_output)
      else $error("brake not engaged after reset");

   // Main scenarios seen
   c_release: cover property ($rose(brake_release_output));
   c_engage: cover property ($fell(brake_release_output));
   c_refused: cover property (pslverr);
endmodule

bind brake_release_sequencer brake_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .servo_on_input(servo_on_input), .motor_speed(motor_speed),
   .brake_release_output(brake_release_output));

// ### sim/tb.sv
// Testbench: register access and brake sequencing scenarios
`timescale 1ns/1ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, servo_on_input;
   logic        pready, pslverr, brake_release_output, brake_locked;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] motor_speed;
   int          miscompares, check_count;

   // Short tick keeps delay units at four cycles
   brake_release_sequencer #(.TICK_CYCLES(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .servo_on_input(servo_on_input), .motor_speed(motor_speed),
      .brake_release_output(brake_release_output));
   brake_relay_model relay (.coil_drive(brake_release_output), .brake_locked(brake_locked));

   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ---------------
   // Shared tasks
   // ---------------
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(string n, logic [11:0] a, logic [31:0] exp, logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(n, exp, r);
      chk({n, " err"}, {31'h0, experr}, {31'h0, e});
   endtask

   // Falling edges until the output shows the level, bounded by lim
   task automatic wait_out(logic lvl, int lim, output int n);
      n = 0;
      while (brake_release_output !== lvl && n < lim) begin
         @(negedge pclk);
         n++;
      end
   endtask

   // ---------------
   // Scenarios
   // ---------------
   task automatic t_regs();
      logic [11:0] ofs[4] = '{12'h000, 12'h004, 12'h008, 12'h00c};
      logic [31:0] rst[4] = '{32'h1, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 4; i++) rd_chk("reset value", ofs[i], rst[i], 1'b0);
      wr(brake_seq_pkg::OFS_OFF_DLY, 32'h0000_a5c3);
      rd_chk("off delay", brake_seq_pkg::OFS_OFF_DLY, 32'h0000_a5c3, 1'b0);
      wr(12'h020, 32'hffff_ffff);
      rd_chk("unmapped", 12'h020, 32'h0, 1'b1);
      $display("test regs done");
   endtask

   task automatic t_delays();
      int n;
      wr(brake_seq_pkg::OFS_SPD_THR, 32'd100);
      wr(brake_seq_pkg::OFS_ON_DLY, 32'd2);
      wr(brake_seq_pkg::OFS_OFF_DLY, 32'd3);
      motor_speed <= 16'h01f4;
      servo_on_input <= 1'b1;
      wait_out(1'b1, 40, n);
      chk("on delay window", 32'h1, {31'h0, n >= 9 && n <= 13});
      chk("relay released", 32'h0, {31'h0, brake_locked});
      rd_chk("status released", brake_seq_pkg::OFS_STATUS, 32'h33, 1'b0);
      servo_on_input <= 1'b0;
      wait_out(1'b0, 40, n);
      chk("off delay window", 32'h1, {31'h0, n >= 13 && n <= 17});
      chk("relay locked", 32'h1, {31'h0, brake_locked});
      $display("test delays done");
   endtask

   task automatic t_slow_motor();
      int n;
      wr(brake_seq_pkg::OFS_ON_DLY, 32'd0);
      wr(brake_seq_pkg::OFS_OFF_DLY, 32'd50);
      motor_speed <= 16'h000a;
      servo_on_input <= 1'b1;
      wait_out(1'b1, 20, n);
      chk("zero on delay", 32'd3, n);
      servo_on_input <= 1'b0;
      wait_out(1'b0, 20, n);
      chk("early engage", 32'h1, {31'h0, n >= 2 && n <= 4});
      $display("test slow motor done");
   endtask

   task automatic t_abort();
      int n;
      wr(brake_seq_pkg::OFS_ON_DLY, 32'd2);
      servo_on_input <= 1'b1;
      repeat (4) @(posedge pclk);
      servo_on_input <= 1'b0;
      wait_out(1'b1, 30, n);
      chk("aborted release", 32'd30, n);
      wr(brake_seq_pkg::OFS_CTRL, 32'h0);
      servo_on_input <= 1'b1;
      wait_out(1'b1, 20, n);
      chk("disabled hold", 32'd20, n);
      servo_on_input <= 1'b0;
      wr(brake_seq_pkg::OFS_CTRL, 32'h1);
      $display("test abort done");
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Reset, then the scenarios in turn
   initial begin
      {presetn, psel, penable, pwrite, servo_on_input} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      motor_speed = 16'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_delays();
      t_slow_motor();
      t_abort();
      end_sim();
   end

   // Watchdog well past the few hundred cycles the tests need
   initial begin
      #500000;
      miscompares++;
      end_sim();
   end
endmodule

// ### verilog/brake_release_sequencer.sv
// Brake release sequencer: servo-on driven brake output with on/off delays and APB registers
//
// Notes on behaviour
// [R01] Output low engages brake, high releases it
// [R02] Separate programmable on and off delays
// [R03] Servo off: engage when off delay expires
// [R04] Servo off: engage early when speed below threshold
// [R05] Brake engages only after servo is off
// [R06] External controller brakes only while decelerating; the output ignores deceleration, which is not an input
// [R07] External brake acts with motor braking direction; the output ignores direction, which is not an input here
// [R08] Servo on: release after on delay expires
`timescale 1ns/1ps
module brake_release_sequencer #(
   parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES
) (
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [11:0]                       paddr,
   input  wire logic [31:0]                       pwdata,
   output logic      [31:0]                       prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic                              servo_on_input,
   input  wire logic [brake_seq_pkg::SPD_W-1:0]   motor_speed,
   output logic                                   brake_release_output
);

   // -------------------------------------------------
   // Register state
   // -------------------------------------------------
   logic                             enable_q;
   logic [brake_seq_pkg::DLY_W-1:0]  on_delay_setting_q;
   logic [brake_seq_pkg::DLY_W-1:0]  off_delay_setting_q;
   logic [brake_seq_pkg::SPD_W-1:0]  speed_threshold_setting_q;
   brake_seq_pkg::seq_state_t        state_q;
   brake_seq_pkg::seq_state_t        state_d;
   logic [brake_seq_pkg::DLY_W-1:0]  delay_cnt_q;
   logic [brake_seq_pkg::TICK_W-1:0] tick_cnt_q;
   logic                             tick;
   logic                             setup_q;
   logic                             servo_active;
   logic                             speed_below;
   logic                             access;
   logic [31:0]                      rdata_d;
   logic                             addr_ok;
   logic                             wr_go;
   logic [31:0]                      status_word;

   // -------------------------------------------------
   // Register map, one 32-bit word each
   // -------------------------------------------------
   // 0x000 control: bit 0 enable, set out of reset
   // 0x004 on delay, 0x008 off delay, in delay units
   // 0x00c speed threshold, same units as motor_speed
   // 0x010 status: output, servo, below, state
   // 0x014 running delay count, read only
   // Upper bits read zero; writes to them are dropped
   // Unmapped offsets answer with pslverr, writes ignored

   // Address decode for the error answer; the read mux has its own case
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == brake_seq_pkg::OFS_CTRL)    || (a == brake_seq_pkg::OFS_ON_DLY)  ||
               (a == brake_seq_pkg::OFS_OFF_DLY) || (a == brake_seq_pkg::OFS_SPD_THR) ||
               (a == brake_seq_pkg::OFS_STATUS)  || (a == brake_seq_pkg::OFS_COUNT);
   endfunction

   assign servo_active = servo_on_input & enable_q;
   // Strictly below; equal speed keeps waiting for the delay
   assign speed_below  = motor_speed < speed_threshold_setting_q;
   assign addr_ok      = mapped(paddr);

   // -------------------------------------------------
   // APB slave: one wait state so prdata comes from a flop
   // -------------------------------------------------
   // Access phase completes on the second penable cycle
   assign access = psel & penable & setup_q;

   // Wait-state tracker: set during first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_q <= 1'b0;
      end else begin
         setup_q <= psel & penable & ~setup_q;
      end
   end

   // Ready is registered, asserted in the completing cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~setup_q;
      end
   end

   // Error flags an unmapped offset alongside ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel & penable & ~setup_q & ~addr_ok;
      end
   end

   // Status word; unused bits read zero
   always_comb begin
      status_word                                 = 32'h0000_0000;
      status_word[brake_seq_pkg::ST_RELEASE_BIT]  = brake_release_output;
      status_word[brake_seq_pkg::ST_SERVO_BIT]    = servo_active;
      status_word[brake_seq_pkg::ST_BELOW_BIT]    = speed_below;
      status_word[brake_seq_pkg::ST_STATE_LSB+:2] = state_q;
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (paddr)
         brake_seq_pkg::OFS_CTRL: begin
            rdata_d[brake_seq_pkg::CTRL_EN_BIT] = enable_q;
         end
         brake_seq_pkg::OFS_ON_DLY: begin
            rdata_d[brake_seq_pkg::DLY_W-1:0] = on_delay_setting_q;
         end
         brake_seq_pkg::OFS_OFF_DLY: begin
            rdata_d[brake_seq_pkg::DLY_W-1:0] = off_delay_setting_q;
         end
         brake_seq_pkg::OFS_SPD_THR: begin
            rdata_d[brake_seq_pkg::SPD_W-1:0] = speed_threshold_setting_q;
         end
         brake_seq_pkg::OFS_STATUS: begin
            rdata_d = status_word;
         end
         brake_seq_pkg::OFS_COUNT: begin
            rdata_d[brake_seq_pkg::DLY_W-1:0] = delay_cnt_q;
         end
         default: begin
            rdata_d = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured in the first access cycle, held until next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & penable & ~setup_q & ~pwrite) begin
         prdata <= rdata_d;
      end
   end

   // Write strobe for one register, shared by every setting
   function automatic logic write_hit(input logic go, input logic [11:0] a,
                                      input logic [11:0] ofs);
      write_hit = go & (a == ofs);
   endfunction

   // Writes take effect at the completing edge only
   assign wr_go = access & pwrite;

   // Enable bit; clearing it forces the servo request inactive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= brake_seq_pkg::CTRL_EN_RST;
      end else if (write_hit(wr_go, paddr, brake_seq_pkg::OFS_CTRL)) begin
         enable_q <= pwdata[brake_seq_pkg::CTRL_EN_BIT];
      end
   end

   // [R02] on delay setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_delay_setting_q <= brake_seq_pkg::ON_DLY_RST;
      end else if (write_hit(wr_go, paddr, brake_seq_pkg::OFS_ON_DLY)) begin
         on_delay_setting_q <= pwdata[brake_seq_pkg::DLY_W-1:0];
      end
   end

   // [R02] off delay setting, kept apart from the on delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_delay_setting_q <= brake_seq_pkg::OFF_DLY_RST;
      end else if (write_hit(wr_go, paddr, brake_seq_pkg::OFS_OFF_DLY)) begin
         off_delay_setting_q <= pwdata[brake_seq_pkg::DLY_W-1:0];
      end
   end

   // Speed threshold for early engagement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_threshold_setting_q <= brake_seq_pkg::SPD_THR_RST;
      end else if (write_hit(wr_go, paddr, brake_seq_pkg::OFS_SPD_THR)) begin
         speed_threshold_setting_q <= pwdata[brake_seq_pkg::SPD_W-1:0];
      end
   end

   // -------------------------------------------------
   // Delay time base
   // -------------------------------------------------
   // Prescaler restarts on every state change so delays start aligned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= '0;
      end else if (state_d != state_q || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end

   assign tick = (tick_cnt_q == brake_seq_pkg::TICK_W'(TICK_CYCLES - 1));

   // -------------------------------------------------
   // Sequencer
   // -------------------------------------------------
   // Engaged and wait-on hold the brake; released and
   // wait-off let the motor turn. A changed setting
   // applies from the next compare, so shortening a delay
   // below the running count lets the count climb to its
   // ceiling and hold there, so the delay never ends; keep settings
   // steady while a delay runs. Speed is compared every
   // cycle, so a noisy speed word can end wait-off early.
   // Losing the servo request in wait-on returns to
   // engaged without ever releasing the brake.
   always_comb begin
      state_d = state_q;
      case (state_q)
         brake_seq_pkg::ST_ENGAGED: begin
            if (servo_active) begin
               state_d = brake_seq_pkg::ST_WAIT_ON;
            end
         end
         brake_seq_pkg::ST_WAIT_ON: begin
            // [R08] release after on delay
            if (!servo_active) begin
               state_d = brake_seq_pkg::ST_ENGAGED;
            end else if (delay_cnt_q == on_delay_setting_q) begin
               state_d = brake_seq_pkg::ST_RELEASED;
            end
         end
         brake_seq_pkg::ST_RELEASED: begin
            // [R05] engage only after servo off
            if (!servo_active) begin
               state_d = brake_seq_pkg::ST_WAIT_OFF;
            end
         end
         brake_seq_pkg::ST_WAIT_OFF: begin
            // [R03] off delay expiry; [R04] low speed engages at once
            if (servo_active) begin
               state_d = brake_seq_pkg::ST_RELEASED;
            end else if (speed_below || delay_cnt_q == off_delay_setting_q) begin
               state_d = brake_seq_pkg::ST_ENGAGED;
            end
         end
         default: begin
            state_d = brake_seq_pkg::ST_ENGAGED;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= brake_seq_pkg::ST_ENGAGED;
      end else begin
         state_q <= state_d;
      end
   end

   // Delay counter in time units; cleared on every state change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_cnt_q <= '0;
      end else if (state_d != state_q) begin
         delay_cnt_q <= '0;
      end else if (tick && delay_cnt_q != {brake_seq_pkg::DLY_W{1'b1}}) begin
         delay_cnt_q <= delay_cnt_q + 1'b1;
      end
   end

   // Pin level for a state: high only in released and wait-off
   function automatic logic released_level(input brake_seq_pkg::seq_state_t s);
      released_level = (s == brake_seq_pkg::ST_RELEASED) || (s == brake_seq_pkg::ST_WAIT_OFF);
   endfunction

   // [R01] output high only in released states
   // Registered from next state so the pin follows the state without lag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brake_release_output <= 1'b0;
      end else begin
         brake_release_output <= released_level(state_d);
      end
   end

endmodule

// ### verilog/brake_seq_pkg.sv
// Package: register map, field widths and reset values for the brake release sequencer
package brake_seq_pkg;

   // -------------------------------------------------
   // Register offsets (byte addresses)
   // -------------------------------------------------
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_ON_DLY   = 12'h004;
   localparam logic [11:0] OFS_OFF_DLY  = 12'h008;
   localparam logic [11:0] OFS_SPD_THR  = 12'h00c;
   localparam logic [11:0] OFS_STATUS   = 12'h010;
   localparam logic [11:0] OFS_COUNT    = 12'h014;

   // -------------------------------------------------
   // Field layout
   // -------------------------------------------------
   localparam int CTRL_EN_BIT     = 0;
   localparam int ST_RELEASE_BIT  = 0;
   localparam int ST_SERVO_BIT    = 1;
   localparam int ST_BELOW_BIT    = 2;
   localparam int ST_STATE_LSB    = 4;
   localparam int DLY_W           = 16;
   localparam int SPD_W           = 16;

   // -------------------------------------------------
   // Reset values
   // -------------------------------------------------
   localparam logic             CTRL_EN_RST  = 1'b1;
   localparam logic [DLY_W-1:0] ON_DLY_RST   = 16'h0000;
   localparam logic [DLY_W-1:0] OFF_DLY_RST  = 16'h0000;
   localparam logic [SPD_W-1:0] SPD_THR_RST  = 16'h0000;

   // -------------------------------------------------
   // Timing: one delay unit in ns, cycles per unit at 40 MHz
   // -------------------------------------------------
   localparam int CLK_PERIOD_NS  = 25;
   localparam int DLY_UNIT_NS    = 1000000;
   localparam int TICK_CYCLES    = DLY_UNIT_NS / CLK_PERIOD_NS;
   localparam int TICK_W         = 16;

   // Sequencer states, Gray coded along engaged->wait_on->released->wait_off
   typedef enum logic [1:0] {
      ST_ENGAGED  = 2'b00,
      ST_WAIT_ON  = 2'b01,
      ST_RELEASED = 2'b11,
      ST_WAIT_OFF = 2'b10
   } seq_state_t;

endpackage
